// *** fcsl_host.sv ***
`timescale 1ns/1ps
// Host controller: issues flash command sequences on CE/WE/OE cycles and polls completion.
// Assumes a word-mode flash whose bus timing is met by FCSL_PHASE_CYC clock cycles per phase.
`include "fcsl_map.svh"
module fcsl_host
	import fcsl_pkg::*;
#(
	parameter int POLL_LIMIT = `FCSL_POLL_LIMIT
)
(
	input  wire logic             CORE_CLK,
	input  wire logic             RESETN,
	input  wire logic             REQ_VALID,
	input  wire fcsl_pkg::fcsl_op_t REQ_OP,
	input  wire logic [20:0]      REQ_ADDR,
	input  wire logic [15:0]      REQ_DATA,
	output logic                  REQ_READY,
	output logic                  RSP_VALID,
	output logic [15:0]           RSP_DATA,
	output logic                  RSP_TIMEOUT,
	output logic                  FLASH_CE_N,
	output logic                  FLASH_WE_N,
	output logic                  FLASH_OE_N,
	output logic [20:0]           FLASH_ADDR,
	output logic [15:0]           FLASH_DQ_OUT,
	output logic                  FLASH_DQ_OE_N,
	input  wire logic [15:0]      FLASH_DQ_IN,
	input  wire logic             FLASH_READY_BUSY
);
	import fcsl_pkg::*;
	localparam logic [3:0] PHASE = 4'(`FCSL_PHASE_CYC);
	fcsl_state_t state_reg;
	fcsl_op_t    op_reg;
	logic [20:0] addr_reg;
	logic [15:0] data_reg;
	logic [2:0]  idx_reg;
	logic [3:0]  phase_reg;
	logic [31:0] poll_cnt_reg;
	logic        poll_prev_reg;
	logic [20:0] rom_addr;
	logic [15:0] rom_data;
	logic [2:0]  rom_count;
	logic        rom_read;
	logic        phase_done;
	logic        last_cycle;
	logic        needs_poll;
	logic        poll_true;
	fcsl_seq_rom u_rom (
		.clk         (CORE_CLK),
		.op          (op_reg),
		.idx         (idx_reg),
		.user_addr   (addr_reg),
		.user_data   (data_reg),
		.cyc_addr    (rom_addr),
		.cyc_data    (rom_data),
		.cyc_count   (rom_count),
		.cyc_is_read (rom_read)
	);
	assign phase_done = (phase_reg == PHASE);
	assign last_cycle = (idx_reg + 3'd1 == rom_count);
	// Operations that start an embedded algorithm end in polling
	assign needs_poll = (op_reg == FCSL_OP_PROGRAM) || (op_reg == FCSL_OP_BYPASS_PROG)
		|| (op_reg == FCSL_OP_CHIP_ERASE) || (op_reg == FCSL_OP_SECT_ERASE);
	// Erase completes with polling bit at 1, program with the true written bit
	assign poll_true = (op_reg == FCSL_OP_CHIP_ERASE || op_reg == FCSL_OP_SECT_ERASE)
		? FLASH_DQ_IN[`FCSL_POLL_BIT]
		: (FLASH_DQ_IN[`FCSL_POLL_BIT] == data_reg[`FCSL_POLL_BIT]);
	// Sequencer
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			state_reg <= FCSL_S_IDLE;
			idx_reg   <= 3'd0;
			phase_reg <= 4'd0;
		end else begin
			phase_reg <= phase_done ? 4'd0 : phase_reg + 4'd1;
			unique case (state_reg)
				FCSL_S_IDLE: begin
					phase_reg <= 4'd0;
					idx_reg   <= 3'd0;
					// Ready gates the take so a request still held at the answer is not run twice
					if (REQ_VALID && REQ_READY) state_reg <= FCSL_S_SETUP;
				end
				FCSL_S_SETUP: if (phase_done) state_reg <= FCSL_S_LOW;
				FCSL_S_LOW:   if (phase_done) state_reg <= FCSL_S_HIGH;
				FCSL_S_HIGH: begin
					if (phase_done) begin
						if (!last_cycle) begin
							idx_reg   <= idx_reg + 3'd1;
							state_reg <= FCSL_S_NEXT;
						end else if (needs_poll) begin
							state_reg <= FCSL_S_POLL;
						end else begin
							state_reg <= FCSL_S_DONE;
						end
					end
				end
				// One idle cycle lets the table register the next cycle
				FCSL_S_NEXT: state_reg <= FCSL_S_SETUP;
				FCSL_S_POLL: begin
					if (phase_done && poll_prev_reg && poll_true) state_reg <= FCSL_S_DONE;
					else if (poll_cnt_reg >= 32'(POLL_LIMIT)) state_reg <= FCSL_S_DONE;
				end
				FCSL_S_DONE: state_reg <= FCSL_S_IDLE;
			endcase
		end
	end
	// Request capture; sequences never run partially, so the device decoder stays in step
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			op_reg    <= FCSL_OP_READ;
			addr_reg  <= 21'h00_0000;
			data_reg  <= 16'h0000;
			REQ_READY <= 1'b0;
		end else begin
			REQ_READY <= (state_reg == FCSL_S_IDLE) && !REQ_VALID;
			if (state_reg == FCSL_S_IDLE && REQ_VALID && REQ_READY) begin
				op_reg   <= REQ_OP;
				addr_reg <= REQ_ADDR;
				data_reg <= REQ_DATA;
			end
		end
	end
	// Bus pins: address before strobe fall, data held past strobe rise
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			FLASH_CE_N    <= 1'b1;
			FLASH_WE_N    <= 1'b1;
			FLASH_OE_N    <= 1'b1;
			FLASH_ADDR    <= 21'h00_0000;
			FLASH_DQ_OUT  <= 16'h0000;
			FLASH_DQ_OE_N <= 1'b1;
		end else begin
			FLASH_CE_N <= !(state_reg == FCSL_S_SETUP || state_reg == FCSL_S_LOW
				|| state_reg == FCSL_S_HIGH || state_reg == FCSL_S_POLL);
			// Write strobe inside chip enable: address at its fall, data at its rise
			FLASH_WE_N <= !(state_reg == FCSL_S_LOW && !rom_read);
			FLASH_OE_N <= !((state_reg == FCSL_S_LOW && rom_read)
				|| (state_reg == FCSL_S_POLL && phase_reg != PHASE));
			FLASH_DQ_OE_N <= !(!rom_read && state_reg != FCSL_S_POLL && state_reg != FCSL_S_IDLE);
			if (state_reg == FCSL_S_SETUP) begin
				FLASH_ADDR   <= rom_addr;
				FLASH_DQ_OUT <= rom_data;
			end
		end
	end
	// Polling watch: two matching samples in a row before data is trusted
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			poll_cnt_reg  <= 32'd0;
			poll_prev_reg <= 1'b0;
		end else if (state_reg != FCSL_S_POLL) begin
			poll_cnt_reg  <= 32'd0;
			poll_prev_reg <= 1'b0;
		end else begin
			poll_cnt_reg <= poll_cnt_reg + 32'd1;
			if (phase_done) poll_prev_reg <= poll_true && FLASH_READY_BUSY;
		end
	end
	// Answer
	always_ff @(posedge CORE_CLK) begin
		if (!RESETN) begin
			RSP_VALID   <= 1'b0;
			RSP_DATA    <= 16'h0000;
			RSP_TIMEOUT <= 1'b0;
		end else begin
			RSP_VALID <= (state_reg == FCSL_S_DONE);
			if (state_reg == FCSL_S_HIGH && rom_read && phase_reg == 4'd0) begin
				RSP_DATA <= FLASH_DQ_IN;
			end
			if (state_reg == FCSL_S_DONE) RSP_TIMEOUT <= needs_poll && (poll_cnt_reg >= 32'(POLL_LIMIT));
		end
	end
endmodule

// *** fcsl_map.svh ***
// Constants for the flash command host controller: command codes, addresses, timing counts.
// Assumes a 100 MHz CORE_CLK and a word-mode flash on a 16-bit data bus.
`ifndef FCSL_MAP_SVH
`define FCSL_MAP_SVH
`define FCSL_ADDR_UNLOCK1   21'h00_0555
`define FCSL_ADDR_UNLOCK2   21'h00_02AA
`define FCSL_ADDR_ID_BASE   21'h00_0000
`define FCSL_ADDR_SEC_ID    21'h00_0003
`define FCSL_ADDR_SECT_ID   21'h00_0002
`define FCSL_ADDR_CFI       21'h00_0055
`define FCSL_D_AA           8'hAA
`define FCSL_D_55           8'h55
`define FCSL_D_PROG         8'hA0
`define FCSL_D_BYPASS       8'h20
`define FCSL_D_AUTOSEL      8'h90
`define FCSL_D_ZERO         8'h00
`define FCSL_D_ERASE_SETUP  8'h80
`define FCSL_D_CHIP         8'h10
`define FCSL_D_SECTOR       8'h30
`define FCSL_D_SUSPEND      8'hB0
`define FCSL_D_RESUME       8'h30
`define FCSL_D_RESET        8'hF0
`define FCSL_D_CFI          8'h98
`define FCSL_D_SECREG_IN    8'h88
`define FCSL_BANK_MSB       20
`define FCSL_BANK_LSB       18
`define FCSL_SECT_LSB       12
`define FCSL_POLL_BIT       7
`define FCSL_CLK_MHZ        100
`define FCSL_PHASE_NS       30
`define FCSL_PHASE_CYC      ((`FCSL_PHASE_NS * `FCSL_CLK_MHZ + 999) / 1000)
`define FCSL_PROT_PROG_US   1
`define FCSL_PROT_ERASE_US  100
`define FCSL_POLL_LIMIT     (`FCSL_PROT_ERASE_US * `FCSL_CLK_MHZ * 1000)
`endif

// *** fcsl_pkg.sv ***
// Types for the flash command host controller.
// Assumes fcsl_map.svh supplies the numeric constants.
package fcsl_pkg;
	typedef enum logic [3:0] {
		FCSL_OP_READ    = 4'h0,
		FCSL_OP_PROGRAM = 4'h1,
		FCSL_OP_BYPASS_IN = 4'h2,
		FCSL_OP_BYPASS_PROG = 4'h3,
		FCSL_OP_BYPASS_OUT = 4'h4,
		FCSL_OP_CHIP_ERASE = 4'h5,
		FCSL_OP_SECT_ERASE = 4'h6,
		FCSL_OP_SUSPEND = 4'h7,
		FCSL_OP_RESUME  = 4'h8,
		FCSL_OP_AUTOSEL = 4'h9,
		FCSL_OP_RESET   = 4'hA,
		FCSL_OP_CFI     = 4'hB,
		FCSL_OP_SECREG_IN = 4'hC,
		FCSL_OP_SECREG_OUT = 4'hD
	} fcsl_op_t;
	typedef enum logic [2:0] {
		FCSL_S_IDLE  = 3'b000,
		FCSL_S_SETUP = 3'b001,
		FCSL_S_LOW   = 3'b010,
		FCSL_S_HIGH  = 3'b011,
		FCSL_S_NEXT  = 3'b100,
		FCSL_S_POLL  = 3'b101,
		FCSL_S_DONE  = 3'b110
	} fcsl_state_t;
endpackage

// *** fcsl_seq_rom.sv ***
`timescale 1ns/1ps
// Command sequence table: address and data of each bus cycle of each operation.
// Assumes synchronous reads; data comes out of a register one cycle after the request.
`include "fcsl_map.svh"
module fcsl_seq_rom
	import fcsl_pkg::*;
(
	input  wire logic             clk,
	input  wire fcsl_pkg::fcsl_op_t op,
	input  wire logic [2:0]       idx,
	input  wire logic [20:0]      user_addr,
	input  wire logic [15:0]      user_data,
	output logic      [20:0]      cyc_addr,
	output logic      [15:0]      cyc_data,
	output logic      [2:0]       cyc_count,
	output logic                  cyc_is_read
);
	import fcsl_pkg::*;
	logic [20:0] a;
	logic [7:0]  d;
	logic [2:0]  n;
	logic        rd;
	logic [20:0] bank;
	// Bank-qualified command address; upper bits above the unlock field are free
	function automatic logic [20:0] at_bank(input logic [20:0] u, input logic [20:0] off);
		at_bank = {u[`FCSL_BANK_MSB:`FCSL_BANK_LSB], off[17:0]};
	endfunction
	// Unlock pair opens every multi-cycle sequence except the two-cycle bypass program and bypass exit
	function automatic logic [28:0] unlock(input logic [2:0] i);
		unlock = (i[0] == 1'b0) ? {`FCSL_ADDR_UNLOCK1, `FCSL_D_AA} : {`FCSL_ADDR_UNLOCK2, `FCSL_D_55};
	endfunction
	always_comb begin
		bank = at_bank(user_addr, 21'h00_0000);
		n    = 3'd1;
		rd   = 1'b0;
		{a, d} = unlock(idx);
		unique case (op)
			FCSL_OP_PROGRAM: begin
				n = 3'd4;
				if (idx == 3'd2) {a, d} = {`FCSL_ADDR_UNLOCK1, `FCSL_D_PROG};
				if (idx == 3'd3) {a, d} = {user_addr, user_data[7:0]};
			end
			FCSL_OP_BYPASS_IN: begin
				n = 3'd3;
				if (idx == 3'd2) {a, d} = {`FCSL_ADDR_UNLOCK1, `FCSL_D_BYPASS};
			end
			FCSL_OP_BYPASS_PROG: begin
				n = 3'd2;
				{a, d} = (idx == 3'd0) ? {`FCSL_ADDR_UNLOCK1, `FCSL_D_PROG} : {user_addr, user_data[7:0]};
			end
			FCSL_OP_BYPASS_OUT: begin
				n = 3'd2;
				{a, d} = (idx == 3'd0) ? {`FCSL_ADDR_UNLOCK1, `FCSL_D_AUTOSEL} : {`FCSL_ADDR_UNLOCK1, `FCSL_D_ZERO};
			end
			FCSL_OP_CHIP_ERASE, FCSL_OP_SECT_ERASE: begin
				n = 3'd6;
				if (idx >= 3'd3) {a, d} = unlock(idx - 3'd3);
				if (idx == 3'd2) {a, d} = {`FCSL_ADDR_UNLOCK1, `FCSL_D_ERASE_SETUP};
				if (idx == 3'd5) begin
					{a, d} = (op == FCSL_OP_CHIP_ERASE) ? {`FCSL_ADDR_UNLOCK1, `FCSL_D_CHIP}
						: {user_addr[20:`FCSL_SECT_LSB], 12'h000, `FCSL_D_SECTOR};
				end
			end
			FCSL_OP_SUSPEND: {a, d} = {bank, `FCSL_D_SUSPEND};
			FCSL_OP_RESUME:  {a, d} = {bank, `FCSL_D_RESUME};
			FCSL_OP_AUTOSEL: begin
				// Fourth cycle reads under the held bank address
				n = 3'd4;
				if (idx == 3'd2) {a, d} = {at_bank(user_addr, `FCSL_ADDR_UNLOCK1), `FCSL_D_AUTOSEL};
				if (idx == 3'd3) begin
					a  = at_bank(user_addr, {9'h000, user_addr[11:0]});
					d  = 8'h00;
					rd = 1'b1;
				end
			end
			FCSL_OP_RESET:  {a, d} = {`FCSL_ADDR_ID_BASE, `FCSL_D_RESET};
			FCSL_OP_CFI:    {a, d} = {`FCSL_ADDR_CFI, `FCSL_D_CFI};
			FCSL_OP_SECREG_IN: begin
				n = 3'd3;
				if (idx == 3'd2) {a, d} = {`FCSL_ADDR_UNLOCK1, `FCSL_D_SECREG_IN};
			end
			FCSL_OP_SECREG_OUT: begin
				n = 3'd4;
				if (idx == 3'd2) {a, d} = {`FCSL_ADDR_UNLOCK1, `FCSL_D_AUTOSEL};
				if (idx == 3'd3) {a, d} = {`FCSL_ADDR_ID_BASE, `FCSL_D_ZERO};
			end
			FCSL_OP_READ: begin
				{a, d} = {user_addr, 8'h00};
				rd = 1'b1;
			end
			default: begin
				{a, d} = {user_addr, 8'h00};
				rd = 1'b1;
			end
		endcase
	end
	// Program value keeps its upper byte; command cycles leave it zero
	always_ff @(posedge clk) begin
		cyc_addr    <= a;
		cyc_data    <= ((op == FCSL_OP_PROGRAM && idx == 3'd3) || (op == FCSL_OP_BYPASS_PROG && idx == 3'd1))
			? user_data : {8'h00, d};
		cyc_count   <= n;
		cyc_is_read <= rd;
	end
endmodule

// *** fcsl_host_props.sv ***
`timescale 1ns/1ps
// Pin and handshake checks for the flash host controller.
// Assumes one clock domain; bound to the host module.
module fcsl_host_props (
	input wire logic        CORE_CLK,
	input wire logic        RESETN,
	input wire logic        RSP_VALID,
	input wire logic        RSP_TIMEOUT,
	input wire logic        FLASH_CE_N,
	input wire logic        FLASH_WE_N,
	input wire logic        FLASH_OE_N,
	input wire logic [20:0] FLASH_ADDR,
	input wire logic [15:0] FLASH_DQ_OUT,
	input wire logic        FLASH_DQ_OE_N,
	input wire logic        FLASH_READY_BUSY
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RESETN);
	// Three cycles meet the shortest write pulse at 100 MHz
	sequence we_pulse;
		!FLASH_WE_N [*3];
	endsequence
	sequence done_ok;
		RSP_VALID && !RSP_TIMEOUT;
	endsequence
	strobe_excl_a: assert property (FLASH_WE_N || FLASH_OE_N)
		else $error("write and read strobes low together");
	write_drives_a: assert property (!FLASH_WE_N |-> !FLASH_CE_N && !FLASH_DQ_OE_N)
		else $error("write strobe without select or data drive");
	read_release_a: assert property (!FLASH_OE_N |-> FLASH_DQ_OE_N)
		else $error("host drives data during a read");
	addr_hold_a: assert property (!FLASH_WE_N |=> $stable(FLASH_ADDR))
		else $error("address moved during write");
	data_hold_a: assert property (!FLASH_WE_N |=> $stable(FLASH_DQ_OUT))
		else $error("write data moved before rising strobe");
	we_width_a: assert property ($fell(FLASH_WE_N) |-> we_pulse)
		else $error("write pulse too short");
	rise_select_a: assert property ($rose(FLASH_WE_N) |-> !FLASH_CE_N)
		else $error("select rose before write strobe");
	done_ready_a: assert property (done_ok |-> FLASH_READY_BUSY)
		else $error("completion reported while device busy");
	timeout_rsp_a: assert property ($rose(RSP_TIMEOUT) |-> RSP_VALID)
		else $error("timeout flag without response");
	rsp_single_a: assert property (RSP_VALID |=> !RSP_VALID)
		else $error("response longer than one cycle");
endmodule
bind fcsl_host fcsl_host_props props_u (.*);

// *** fcsl_flash_model.sv ***
`timescale 1ns/1ps
// Behavioural word-mode flash: command decode, status polling, ready/busy.
// Assumes host strobes; stall holds the device busy to force a timeout.
module fcsl_flash_model #(
	parameter logic [15:0] SEC_CODE = 16'h0082,
	parameter int          BUSY_NS  = 500,
	parameter logic [8:0]  PROT_SECT = 9'h1F0, // Arbitrary choice of the one locked sector
	parameter int          PROT_PROG_NS  = 1_000,
	parameter int          PROT_ERASE_NS = 100_000
) (
	input  wire logic        ce_n,
	input  wire logic        we_n,
	input  wire logic        oe_n,
	input  wire logic [20:0] addr,
	input  wire logic [15:0] dq_out,
	input  wire logic        dq_oe_n,
	input  wire logic        stall,
	output logic      [15:0] dq_in,
	output logic             ready_busy
);
	logic [20:0] pa = '0;
	logic [15:0] pv = 16'hFFFF;
	logic [20:0] la = '0;
	logic        pb = 1'b1;
	logic        hit = 1'b1;
	logic        wipe = 1'b1;
	logic [15:0] rd;
	logic [7:0]  d;
	logic [11:0] a;
	logic        byp = 1'b0;
	logic        idm = 1'b0;
	logic        ers = 1'b0;
	logic        busy = 1'b0;
	int          step = 0;
	event        go;
	// Address latches at the later of the two strobe falls
	always @(negedge we_n or negedge ce_n) begin
		if (!we_n && !ce_n) la = addr;
	end
	always @(posedge we_n) begin
		if (!ce_n) begin
			d = dq_out[7:0];
			a = la[11:0];
			if (d == 8'hF0) begin
				step = 0;
				idm = 1'b0;
			end else case (step)
				0: if (a == 12'h555 && d == 8'hAA) step = 1;
					else if (byp && d == 8'hA0) step = 5;
					else if (byp && d == 8'h90) step = 6;
					else if (d == 8'h98 && !busy) idm = 1'b1;
					else if (d == 8'h00) idm = 1'b0;
				1: step = (a == 12'h2AA && d == 8'h55) ? 2 : 0;
				2: begin
					step = (d == 8'hA0) ? 5 : (d == 8'h80) ? 3 : 0;
					byp = byp || d == 8'h20;
					idm = idm || d == 8'h90;
				end
				3: step = (d == 8'hAA) ? 4 : 0;
				4: step = (d == 8'h55) ? 7 : 0;
				5: begin
					hit = la[20:12] != PROT_SECT;
					pb  = dq_out[7];
					if (hit) begin
						pa = la;
						pv = dq_out;
					end
					ers = 1'b0;
					step = 0;
					-> go;
				end
				6: begin
					byp = 1'b0;
					step = 0;
				end
				default: begin
					step = 0;
					ers = d == 8'h10 || d == 8'h30;
					hit  = d == 8'h10 || la[20:12] != PROT_SECT;
					wipe = d == 8'h10 || la[20:12] == pa[20:12];
					if (ers) -> go;
				end
			endcase
		end
	end
	always @(go) begin
		busy = 1'b1;
		// A locked target only shows status for a while, then reads the array again
		#(hit ? BUSY_NS : ers ? PROT_ERASE_NS : PROT_PROG_NS);
		wait (!stall);
		busy = 1'b0;
		if (ers && hit && wipe) pv = 16'hFFFF;
	end
	always_comb begin
		if (busy) rd = ers ? 16'h0000 : {pv[15:8], ~pb, pv[6:0]};
		else if (idm) rd = (addr[7:0] == 8'h03) ? SEC_CODE : 16'h0000;
		else rd = (addr == pa) ? pv : 16'hFFFF;
	end
	assign ready_busy = !busy;
	// Released bus shows the inverse, never a lucky match
	assign dq_in = (!ce_n && !oe_n && dq_oe_n) ? rd : ~rd;
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ps
// Self-checking bench: host controller driving a behavioural flash.
// Assumes each operation completes within a few thousand cycles.
module tb_top;
	import fcsl_pkg::*;
	localparam logic [20:0] A1 = 21'h04_1000;
	localparam logic [20:0] A2 = 21'h10_2008;
	localparam logic [20:0] A3 = 21'h1F_0010;
	logic        clk;
	logic        resetn;
	logic        req_valid;
	fcsl_op_t    req_op;
	logic [20:0] req_addr;
	logic [15:0] req_data;
	logic        req_ready;
	logic        rsp_valid;
	logic [15:0] rsp_data;
	logic        rsp_tmo;
	logic        ce_n;
	logic        we_n;
	logic        oe_n;
	logic [20:0] f_addr;
	logic [15:0] dq_out;
	logic        dq_oe_n;
	logic [15:0] dq_in;
	logic        rdy;
	logic        stall;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	fcsl_host #(.POLL_LIMIT(200)) dut_u (.CORE_CLK(clk), .RESETN(resetn), .REQ_VALID(req_valid),
		.REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_DATA(req_data), .REQ_READY(req_ready),
		.RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .RSP_TIMEOUT(rsp_tmo), .FLASH_CE_N(ce_n),
		.FLASH_WE_N(we_n), .FLASH_OE_N(oe_n), .FLASH_ADDR(f_addr), .FLASH_DQ_OUT(dq_out),
		.FLASH_DQ_OE_N(dq_oe_n), .FLASH_DQ_IN(dq_in), .FLASH_READY_BUSY(rdy));
	fcsl_flash_model flash_u (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(f_addr),
		.dq_out(dq_out), .dq_oe_n(dq_oe_n), .stall(stall), .dq_in(dq_in), .ready_busy(rdy));
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Holds the request until the one-cycle answer, then one idle cycle
	task automatic op(input fcsl_op_t o, input logic [20:0] a, input logic [15:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		req_op <= o;
		req_addr <= a;
		req_data <= d;
		req_valid <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 20000);
		req_valid <= 1'b0;
		if (n >= 20000) chk("answer", 16'h0000, 16'h0001);
		@(posedge clk);
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		#800_000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		{resetn, req_valid, stall, req_addr, req_data} = '0;
		req_op = FCSL_OP_READ;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		op(FCSL_OP_READ, A1, 16'h0000);
		chk("erased read", rsp_data, 16'hFFFF);
		op(FCSL_OP_PROGRAM, A1, 16'h1234);
		chk("program tmo", rsp_tmo, 16'h0000);
		op(FCSL_OP_READ, A1, 16'h0000);
		chk("program read", rsp_data, 16'h1234);
		op(FCSL_OP_BYPASS_IN, A2, 16'h0000);
		op(FCSL_OP_BYPASS_PROG, A2, 16'h5678);
		chk("bypass tmo", rsp_tmo, 16'h0000);
		op(FCSL_OP_BYPASS_OUT, A2, 16'h0000);
		op(FCSL_OP_READ, A2, 16'h0000);
		chk("bypass read", rsp_data, 16'h5678);
		op(FCSL_OP_AUTOSEL, 21'h04_0003, 16'h0000);
		chk("secured code", {8'h00, rsp_data[7:0]}, 16'h0082);
		op(FCSL_OP_RESET, A1, 16'h0000);
		op(FCSL_OP_AUTOSEL, 21'h04_1002, 16'h0000);
		chk("protect code", {8'h00, rsp_data[7:0]}, 16'h0000);
		op(FCSL_OP_RESET, A1, 16'h0000);
		op(FCSL_OP_READ, A2, 16'h0000);
		chk("read after reset", rsp_data, 16'h5678);
		op(FCSL_OP_SUSPEND, A2, 16'h0000);
		op(FCSL_OP_RESUME, A2, 16'h0000);
		op(FCSL_OP_SECREG_IN, A1, 16'h0000);
		op(FCSL_OP_SECREG_OUT, A1, 16'h0000);
		op(FCSL_OP_READ, A2, 16'h0000);
		chk("read after exits", rsp_data, 16'h5678);
		op(FCSL_OP_CFI, A1, 16'h0000);
		chk("query tmo", rsp_tmo, 16'h0000);
		op(FCSL_OP_RESET, A1, 16'h0000);
		op(FCSL_OP_SECT_ERASE, A2, 16'h0000);
		chk("erase tmo", rsp_tmo, 16'h0000);
		op(FCSL_OP_READ, A2, 16'h0000);
		chk("sector erased", rsp_data, 16'hFFFF);
		op(FCSL_OP_PROGRAM, A3, 16'h0080);
		chk("locked tmo", rsp_tmo, 16'h0000);
		op(FCSL_OP_READ, A3, 16'h0000);
		chk("locked kept", rsp_data, 16'hFFFF);
		stall <= 1'b1;
		op(FCSL_OP_PROGRAM, A1, 16'h00AA);
		chk("stuck tmo", rsp_tmo, 16'h0001);
		stall <= 1'b0;
		op(FCSL_OP_RESET, A1, 16'h0000);
		op(FCSL_OP_CHIP_ERASE, A1, 16'h0000);
		op(FCSL_OP_READ, A1, 16'h0000);
		chk("chip erased", rsp_data, 16'hFFFF);
		end_of_test();
	end
endmodule
